// ### sscr_pkg.sv
// Constants, register map and state types for the sync status and calibration register group.
// Assumes a 100 MHz system clock and 8-bit registers on word-aligned APB addresses.
`default_nettype none
package sscr_pkg;

  localparam logic [7:0] IDX_ACT = 8'h24;
  localparam logic [7:0] IDX_POL = 8'h25;
  localparam logic [7:0] IDX_CNT_HI = 8'h26;
  localparam logic [7:0] IDX_CNT_LO = 8'h27;
  localparam logic [7:0] IDX_TEST_ONE = 8'h28;
  localparam logic [7:0] IDX_TEST_TWO = 8'h29;
  localparam logic [7:0] IDX_TEST_THREE = 8'h2a;
  localparam logic [7:0] IDX_TEST_FOUR = 8'h2b;
  localparam logic [7:0] IDX_OFS_HOLD = 8'h2c;
  localparam logic [7:0] IDX_TEST_FIVE = 8'h2d;
  localparam logic [7:0] IDX_TEST_SIX = 8'h2e;
  localparam logic [7:0] IDX_SRC_SEL = 8'h30;
  localparam logic [7:0] IDX_CAL_STAT = 8'h31;
  localparam logic [7:0] IDX_GREEN_FILT = 8'h34;
  localparam logic [7:0] IDX_GEAR = 8'h36;
  localparam logic [7:0] IDX_GAIN = 8'h3c;

  localparam int OFS_HOLD_BIT = 4;
  localparam int GREEN_FILT_BIT = 2;
  localparam int GEAR_BIT = 0;
  localparam int GAIN_HOLD_BIT = 3;
  localparam int EQ_FLAG_BIT = 1;
  localparam int SRC_SEL_BIT = 0;
  localparam logic [2:0] GAIN_EN_OFF = 3'h0;
  localparam logic [2:0] GAIN_EN_ON = 3'h6;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Input order equals the bit order of the activity register.
  localparam int IN_CLAMP = 0;
  localparam int IN_HOLDOVER = 1;
  localparam int IN_GREEN_B = 2;
  localparam int IN_GREEN_A = 3;
  localparam int IN_FRAME_B = 4;
  localparam int IN_FRAME_A = 5;
  localparam int IN_LINE_B = 6;
  localparam int IN_LINE_A = 7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ACT_TIMEOUT_MS = 50;
  localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GREEN_MIN_NS = 250;
  localparam int GREEN_MIN_CYC = (GREEN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_UPDATES = 4'ha;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
    logic [7:0] act;
    logic [7:0][22:0] idle;
    logic [7:0][15:0] run;
    logic [7:0][15:0] hi_len;
    logic [7:0][15:0] lo_len;
    logic [1:0] g_out;
    logic [1:0][4:0] g_cnt;
    logic [15:0] line_per;
    logic [15:0] line_prev;
    logic eq_seen;
    logic eq_flag;
    logic [11:0] line_cnt;
    logic [11:0] lines;
    logic [7:0] test_one;
    logic [7:0] test_two;
    logic [7:0] test_five;
    logic [7:0] test_six;
    logic [7:0] ofs_reg;
    logic [7:0] green_reg;
    logic [7:0] gear_reg;
    logic [7:0] gain_reg;
    logic src_b;
    logic [3:0] ofs_upd;
    logic [3:0] gain_upd;
    logic ofs_run;
    logic gain_run;
    logic gain_on;
    logic low_gear;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } sscr_state_t;

endpackage : sscr_pkg
`default_nettype wire

// ### sscr_regs.sv
// Sync status and calibration register group with an APB slave port.
// Assumes sync pins are asynchronous to mclk and calibration update ticks are mclk pulses.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sscr_regs #(
  parameter int ACT_TIMEOUT_CYC = sscr_pkg::ACT_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic line_sync_in_a,
  input wire logic line_sync_in_b,
  input wire logic frame_sync_in_a,
  input wire logic frame_sync_in_b,
  input wire logic green_sync_in_a,
  input wire logic green_sync_in_b,
  input wire logic ext_clock_or_holdover_pin,
  input wire logic clamp_pin,
  input wire logic offset_update_tick,
  input wire logic gain_update_tick,
  output logic offset_update_en,
  output logic gain_update_en,
  output logic gain_match_on,
  output logic pll_oscillator_low_gear,
  output logic green_embedded_sync_a,
  output logic green_embedded_sync_b
);

  sscr_pkg::sscr_state_t q, d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a[7:2] == idx[5:0]) && (a[1:0] == 2'h0);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, sscr_pkg::IDX_ACT) || hit(a, sscr_pkg::IDX_POL) ||
      hit(a, sscr_pkg::IDX_CNT_HI) || hit(a, sscr_pkg::IDX_CNT_LO) ||
      hit(a, sscr_pkg::IDX_TEST_ONE) || hit(a, sscr_pkg::IDX_TEST_TWO) ||
      hit(a, sscr_pkg::IDX_TEST_THREE) || hit(a, sscr_pkg::IDX_TEST_FOUR) ||
      hit(a, sscr_pkg::IDX_OFS_HOLD) || hit(a, sscr_pkg::IDX_TEST_FIVE) ||
      hit(a, sscr_pkg::IDX_TEST_SIX) || hit(a, sscr_pkg::IDX_SRC_SEL) ||
      hit(a, sscr_pkg::IDX_CAL_STAT) || hit(a, sscr_pkg::IDX_GREEN_FILT) ||
      hit(a, sscr_pkg::IDX_GEAR) || hit(a, sscr_pkg::IDX_GAIN);
  endfunction : mapped

  // Polarity is positive when the high phase is the shorter one.
  function automatic logic pol(input sscr_pkg::sscr_state_t s, input int i);
    pol = s.hi_len[i] < s.lo_len[i];
  endfunction : pol

  function automatic logic [7:0] rd(input sscr_pkg::sscr_state_t s, input logic [7:0] a);
    rd = 8'h00;
    if (hit(a, sscr_pkg::IDX_ACT)) begin
      rd = s.act;
    end
    if (hit(a, sscr_pkg::IDX_POL)) begin
      rd[7] = pol(s, sscr_pkg::IN_LINE_A);
      rd[6] = pol(s, sscr_pkg::IN_LINE_B);
      rd[5] = pol(s, sscr_pkg::IN_FRAME_A);
      rd[4] = pol(s, sscr_pkg::IN_FRAME_B);
      rd[3] = pol(s, sscr_pkg::IN_HOLDOVER);
      rd[2] = pol(s, sscr_pkg::IN_CLAMP);
      rd[sscr_pkg::EQ_FLAG_BIT] = s.eq_flag;
    end
    if (hit(a, sscr_pkg::IDX_CNT_HI)) begin
      rd = s.lines[11:4];
    end
    if (hit(a, sscr_pkg::IDX_CNT_LO)) begin
      rd = {s.lines[3:0], 4'h0};
    end
    if (hit(a, sscr_pkg::IDX_TEST_ONE)) begin
      rd = s.test_one;
    end
    if (hit(a, sscr_pkg::IDX_TEST_THREE) || hit(a, sscr_pkg::IDX_TEST_FOUR)) begin
      rd = 8'h00;
    end
    if (hit(a, sscr_pkg::IDX_TEST_TWO)) begin
      rd = s.test_two;
    end
    if (hit(a, sscr_pkg::IDX_OFS_HOLD)) begin
      rd = s.ofs_reg;
    end
    if (hit(a, sscr_pkg::IDX_TEST_FIVE)) begin
      rd = s.test_five;
    end
    if (hit(a, sscr_pkg::IDX_TEST_SIX)) begin
      rd = s.test_six;
    end
    if (hit(a, sscr_pkg::IDX_SRC_SEL)) begin
      rd[sscr_pkg::SRC_SEL_BIT] = s.src_b;
    end
    if (hit(a, sscr_pkg::IDX_CAL_STAT)) begin
      rd[0] = (s.ofs_upd == sscr_pkg::SETTLE_UPDATES);
      rd[1] = (s.gain_upd == sscr_pkg::SETTLE_UPDATES);
    end
    if (hit(a, sscr_pkg::IDX_GREEN_FILT)) begin
      rd = s.green_reg;
    end
    if (hit(a, sscr_pkg::IDX_GEAR)) begin
      rd = s.gear_reg;
    end
    if (hit(a, sscr_pkg::IDX_GAIN)) begin
      rd = s.gain_reg;
    end
  endfunction : rd

  logic [7:0] pins;
  assign pins = {line_sync_in_a, line_sync_in_b, frame_sync_in_a, frame_sync_in_b,
    green_sync_in_a, green_sync_in_b, ext_clock_or_holdover_pin, clamp_pin};

  always_comb begin
    logic [7:0] edge_seen;
    logic [7:0] wd;
    logic wr;
    logic line_lvl;
    logic line_old;
    logic line_lead;
    logic frame_lead;
    logic eq_now;
    int li;
    int fi;
    edge_seen = 8'h00;
    wd = pwdata[7:0];
    wr = 1'b0;
    line_lvl = 1'b0;
    line_old = 1'b0;
    line_lead = 1'b0;
    frame_lead = 1'b0;
    eq_now = 1'b0;
    li = 0;
    fi = 0;
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 8; i++) begin
      // A pin change counts only once the later two stages agree.
      if (q.s2[i] == q.s3[i] && q.s3[i] != q.lvl[i]) begin
        d.lvl[i] = q.s3[i];
        edge_seen[i] = 1'b1;
      end
      if (edge_seen[i]) begin
        d.act[i] = 1'b1;
        d.idle[i] = 23'h0;
        d.run[i] = 16'h0;
        if (q.lvl[i]) begin
          d.hi_len[i] = q.run[i];
        end else begin
          d.lo_len[i] = q.run[i];
        end
      end else begin
        if (q.idle[i] >= 23'(ACT_TIMEOUT_CYC - 1)) begin
          d.act[i] = 1'b0;
        end else begin
          d.idle[i] = q.idle[i] + 23'h1;
        end
        if (q.run[i] != 16'hffff) begin
          d.run[i] = q.run[i] + 16'h1;
        end
      end
    end
    for (int g = 0; g < 2; g++) begin
      if (!q.green_reg[sscr_pkg::GREEN_FILT_BIT] ||
          q.lvl[sscr_pkg::IN_GREEN_B + g] == q.g_out[g]) begin
        d.g_out[g] = q.lvl[sscr_pkg::IN_GREEN_B + g];
        d.g_cnt[g] = 5'h0;
      end else if (q.g_cnt[g] >= 5'(sscr_pkg::GREEN_MIN_CYC - 1)) begin
        d.g_out[g] = q.lvl[sscr_pkg::IN_GREEN_B + g];
        d.g_cnt[g] = 5'h0;
      end else begin
        d.g_cnt[g] = q.g_cnt[g] + 5'h1;
      end
    end
    li = q.src_b ? sscr_pkg::IN_LINE_B : sscr_pkg::IN_LINE_A;
    fi = q.src_b ? sscr_pkg::IN_FRAME_B : sscr_pkg::IN_FRAME_A;
    line_lvl = d.lvl[li];
    line_old = q.lvl[li];
    // Leading edge follows the measured polarity of each sync.
    line_lead = edge_seen[li] && (line_lvl == pol(q, li)) && (line_old != line_lvl);
    frame_lead = edge_seen[fi] && (d.lvl[fi] == pol(q, fi));
    if (q.line_per != 16'hffff) begin
      d.line_per = q.line_per + 16'h1;
    end
    if (line_lead) begin
      d.line_per = 16'h0;
      d.line_prev = q.line_per;
      eq_now = q.line_per < {1'b0, q.line_prev[15:1]};
      if (q.line_cnt != 12'hfff) begin
        d.line_cnt = q.line_cnt + 12'h1;
      end
    end
    if (frame_lead) begin
      d.lines = q.line_cnt;
      d.line_cnt = line_lead ? 12'h1 : 12'h0;
      d.eq_flag = q.eq_seen || eq_now;
      d.eq_seen = 1'b0;
    end else if (eq_now) begin
      d.eq_seen = 1'b1;
    end
    d.rdy = 1'b0;
    d.err = 1'b0;
    if (psel && penable && !q.rdy) begin
      d.rdy = 1'b1;
      d.err = !mapped(paddr);
      d.rdata = pwrite ? 32'h0 : {24'h0, rd(q, paddr)};
    end
    wr = psel && penable && q.rdy && pwrite && !q.err;
    // test fields one, two, five and six stay writable for software; three and four are not stored
    if (wr && hit(paddr, sscr_pkg::IDX_TEST_ONE)) begin
      d.test_one = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_TEST_TWO)) begin
      d.test_two = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_TEST_FIVE)) begin
      d.test_five = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_TEST_SIX)) begin
      d.test_six = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_OFS_HOLD)) begin
      d.ofs_reg = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_GREEN_FILT)) begin
      d.green_reg = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_GEAR)) begin
      d.gear_reg = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_GAIN)) begin
      d.gain_reg = wd;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_SRC_SEL)) begin
      d.src_b = wd[sscr_pkg::SRC_SEL_BIT];
    end
    // update count restarts when a hold bit rises
    if (q.ofs_run && offset_update_tick && q.ofs_upd != sscr_pkg::SETTLE_UPDATES) begin
      d.ofs_upd = q.ofs_upd + 4'h1;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_OFS_HOLD) && wd[sscr_pkg::OFS_HOLD_BIT] &&
        !q.ofs_reg[sscr_pkg::OFS_HOLD_BIT]) begin
      d.ofs_upd = 4'h0;
    end
    if (q.gain_run && gain_update_tick && q.gain_upd != sscr_pkg::SETTLE_UPDATES) begin
      d.gain_upd = q.gain_upd + 4'h1;
    end
    if (wr && hit(paddr, sscr_pkg::IDX_GAIN) && wd[sscr_pkg::GAIN_HOLD_BIT] &&
        !q.gain_reg[sscr_pkg::GAIN_HOLD_BIT]) begin
      d.gain_upd = 4'h0;
    end
    d.ofs_run = q.ofs_reg[sscr_pkg::OFS_HOLD_BIT];
    d.gain_on = (q.gain_reg[2:0] == sscr_pkg::GAIN_EN_ON);
    d.gain_run = q.gain_reg[sscr_pkg::GAIN_HOLD_BIT] && (q.gain_reg[2:0] == sscr_pkg::GAIN_EN_ON);
    d.low_gear = q.gear_reg[sscr_pkg::GEAR_BIT];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.rdy;
  assign pslverr = q.err;
  assign offset_update_en = q.ofs_run;
  assign gain_update_en = q.gain_run;
  assign gain_match_on = q.gain_on;
  assign pll_oscillator_low_gear = q.low_gear;
  assign green_embedded_sync_a = q.g_out[1];
  assign green_embedded_sync_b = q.g_out[0];

endmodule : sscr_regs
`default_nettype wire

// ### sscr_regs_monitor.sv
// Port checker for the sync status and calibration register group.
// Assumes it is bound to sscr_regs and that APB answers with one wait state.
`timescale 1ns/100ps
`default_nettype none
module sscr_regs_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic offset_update_en,
  input wire logic gain_update_en,
  input wire logic gain_match_on,
  input wire logic pll_oscillator_low_gear
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_ready_wait:
    assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_upper_zero:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_err_unmapped:
    assert property (pready && paddr == 8'h00 |-> pslverr) else $error("no slave error");
  a_err_mapped:
    assert property (pready && paddr == 8'h90 |-> !pslverr) else $error("false slave error");
  a_rsvd_zero:
    assert property (pready && !pwrite && paddr == 8'ha8 |-> prdata == 32'h0)
    else $error("reserved read not zero");
  a_ofs_hold:
    assert property (pready && pwrite && paddr == 8'hb0 |->
      ##2 offset_update_en == $past(pwdata[4], 2)) else $error("offset enable wrong");
  a_gear_sel:
    assert property (pready && pwrite && paddr == 8'hd8 |->
      ##2 pll_oscillator_low_gear == $past(pwdata[0], 2)) else $error("gear wrong");
  a_gain_field:
    assert property (pready && pwrite && paddr == 8'hf0 |->
      ##2 gain_match_on == ($past(pwdata[2:0], 2) == 3'h6)) else $error("gain enable wrong");
  a_gain_hold:
    assert property (pready && pwrite && paddr == 8'hf0 |->
      ##2 gain_update_en == ($past(pwdata[3], 2) && ($past(pwdata[2:0], 2) == 3'h6)))
    else $error("gain update enable wrong");
  a_rst_idle:
    assert property ($past(sys_rst) |-> !gain_update_en && !offset_update_en && !pready)
    else $error("outputs active after reset");
endmodule : sscr_regs_monitor
`default_nettype wire

// ### sscr_regs_tb.sv
// Self-checking bench for the sync status and calibration register group.
// Assumes one APB wait state; the activity timeout is shortened to keep the run short.
`timescale 1ns/100ps
`default_nettype none
module sscr_regs_tb;
  localparam int TO = 200;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, pins = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, slv, ot = 1'b0, gt = 1'b0, oe, ge, gm, lg, ga, gb;
  logic [7:0] rw [8] = '{8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h34, 8'h36, 8'h3c};
  logic [7:0] gv [4] = '{8'h0e, 8'h06, 8'h08, 8'h00};
  int err_total = 0, checks = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    ot <= ($urandom % 8) == 0;
    gt <= ($urandom % 8) == 0;
  end

  sscr_regs #(.ACT_TIMEOUT_CYC(TO)) dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_sync_in_a(pins[7]), .line_sync_in_b(pins[6]),
    .frame_sync_in_a(pins[5]), .frame_sync_in_b(pins[4]), .green_sync_in_a(pins[3]),
    .green_sync_in_b(pins[2]), .ext_clock_or_holdover_pin(pins[1]), .clamp_pin(pins[0]),
    .offset_update_tick(ot), .gain_update_tick(gt), .offset_update_en(oe),
    .gain_update_en(ge), .gain_match_on(gm), .pll_oscillator_low_gear(lg),
    .green_embedded_sync_a(ga), .green_embedded_sync_b(gb));

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the whole request until pready is sampled high, then releases it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      err_total++;
      end_sim();
    end
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {i[5:0], 2'b00}, {24'h0, d});
  endtask : wr

  task automatic rdc(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, {i[5:0], 2'b00}, 32'h0);
    chk(rv & {24'hffffff, m}, {24'h0, e & m});
  endtask : rdc

  task automatic tog(input int i, input int hi, input int n);
    repeat (n) begin
      pins[i] <= 1'b1;
      repeat (hi) @(posedge mclk);
      pins[i] <= 1'b0;
      repeat (100 - hi) @(posedge mclk);
    end
  endtask : tog

  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    end_sim();
  end

  initial begin
    int n, hi, p;
    logic [7:0] d;
    logic f;
    logic fb;
    void'($urandom(32'h6471604a));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (rw[k]) rdc(rw[k], 8'h00, 8'hff);
    foreach (rw[k]) begin
      d = 8'($urandom);
      wr(rw[k], d);
      rdc(rw[k], d, 8'hff);
    end
    for (int a = 8'h2a; a < 8'h2c; a++) begin
      wr(8'(a), 8'($urandom));
      rdc(8'(a), 8'h00, 8'hff);
    end
    apb(1'b0, 8'h00, 32'h0);
    chk(slv, 1'b1);
    // fixed values for the test fields.
    wr(8'h28, 8'hbf);
    wr(8'h29, 8'h00);
    wr(8'h2d, 8'he8);
    wr(8'h2e, 8'he0);
    wr(8'h2c, 8'h10);
    @(posedge mclk);
    chk(oe, 1'b1);
    wr(8'h2c, 8'h00);
    @(posedge mclk);
    chk(oe, 1'b0);
    foreach (gv[k]) begin
      wr(8'h3c, gv[k]);
      @(posedge mclk);
      chk(gm, gv[k][2:0] == 3'h6);
      chk(ge, gv[k][2:0] == 3'h6 && gv[k][3]);
    end
    for (int k = 1; k >= 0; k--) begin
      wr(8'h36, 8'(k));
      @(posedge mclk);
      chk(lg, k[0]);
    end
    // both loops are left updating continuously after a hold rise.
    wr(8'h2c, 8'h10);
    wr(8'h3c, 8'h0e);
    rdc(8'h31, 8'h00, 8'h03);
    repeat (300) @(posedge mclk);
    rdc(8'h31, 8'h03, 8'h03);
    // one pin at a time, then idle past the timeout.
    for (int i = 0; i < 8; i++) begin
      hi = ($urandom % 2) ? 20 : 80;
      tog(i, hi, 3);
      rdc(8'h24, 8'h01 << i, 8'hff);
      p = (i == 0) ? 2 : (i == 1) ? 3 : i;
      d = 8'h01 << p;
      if (i < 2 || i > 3) rdc(8'h25, (hi < 50) ? d : 8'h00, d);
      repeat (TO + 50) @(posedge mclk);
      rdc(8'h24, 8'h00, 8'hff);
    end
    // Short green pulses vanish only while the filter is on.
    for (int k = 0; k < 4; k++) begin
      wr(8'h34, k[1] ? 8'h04 : 8'h00);
      n = k[0] ? 40 : 10;
      f = 1'b0;
      fb = 1'b0;
      pins[3:2] <= 2'b11;
      repeat (n) begin
        @(posedge mclk);
        f = f | ga;
        fb = fb | gb;
      end
      pins[3:2] <= 2'b00;
      repeat (40) begin
        @(posedge mclk);
        f = f | ga;
        fb = fb | gb;
      end
      chk(f, !k[1] || n > sscr_pkg::GREEN_MIN_CYC);
      chk(fb, !k[1] || n > sscr_pkg::GREEN_MIN_CYC);
    end
    // n positive line pulses between positive frame pulses, on both sources.
    for (int s = 0; s < 2; s++) begin
      wr(8'h30, 8'(s));
      n = $urandom_range(60, 20);
      repeat (3) begin
        pins[5 - s] <= 1'b1;
        repeat (10) @(posedge mclk);
        pins[5 - s] <= 1'b0;
        tog(7 - s, 5, n);
      end
      pins[5 - s] <= 1'b1;
      repeat (10) @(posedge mclk);
      pins[5 - s] <= 1'b0;
      repeat (10) @(posedge mclk);
      rdc(8'h26, 8'(n >> 4), 8'hff);
      rdc(8'h27, {n[3:0], 4'h0}, 8'hf0);
      rdc(8'h25, 8'h00, 8'h02);
    end
    end_sim();
  end
endmodule : sscr_regs_tb

bind sscr_regs sscr_regs_monitor mon (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .offset_update_en(offset_update_en),
  .gain_update_en(gain_update_en), .gain_match_on(gain_match_on),
  .pll_oscillator_low_gear(pll_oscillator_low_gear));
`default_nettype wire
